// ==== core/crxs_rx_storage.sv ====
// crxs_rx_storage: receive buffers, two receive fifos and partial
// network mode control behind a plain register port
// assumes the protocol engine hands over filtered frames as one-cycle
// store pulses, all inputs synchronous to clk_in
//
// Functional notes
// - stored pn-matched frame moves pn mode control to recovery target
// - recovery target 11 keeps pn mode; only channel reset or a keyed write leaves it
// - pn mode control write takes effect only with key c4 in same write
// - pn status follows control one clock later, or after reception completes
// - in pn mode store only frames passing id and payload filter; raise irq
// - up to 16 shared receive buffers, newest frame overwrites
// - storing into buffer n sets its new-data flag
// - dce and dre both set: store rule dlc, else received dlc
// - store rule label: 16-bit pointer plus two flag bits
// - payload bytes beyond received dlc read as 00
// - two shared receive fifos, configured depth, first-in first-out
// - each fifo store increments the 6-bit message count
// - full flag when count equals depth from 3-bit depth field
// - empty flag once every stored frame was released
// - write ff to pointer field advances read position, count drops
// - classical frames store brs and esi as 0
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module crxs_rx_storage
  import crxs_pkg::*;
#(
  parameter int unsigned NUM_BUF    = 16,
  parameter int unsigned FIFO_DEPTH = 16,
  parameter int unsigned DATA_WORDS = 2
) (
  input  wire logic                    clk_in,          // module clock
  input  wire logic                    rst_n_in,        // async reset, low
  input  wire logic [crxs_pkg::ADDR_W-1:0] reg_addr_in, // byte address
  input  wire logic [31:0]             reg_wdata_in,    // write data
  input  wire logic                    reg_wr_in,       // write strobe
  input  wire logic                    reg_rd_in,       // read strobe
  output logic      [31:0]             reg_rdata_out,   // read data, next cycle
  input  wire logic                    eng_store_in,    // filtered frame pulse
  input  wire logic                    eng_to_buf_in,   // route to buffer
  input  wire logic [3:0]              eng_buf_idx_in,  // buffer index
  input  wire logic [1:0]              eng_to_fifo_in,  // route to fifo k
  input  wire logic                    eng_pn_match_in, // id and payload pass
  input  wire logic [31:0]             eng_id_in,       // id word
  input  wire logic [3:0]              eng_dlc_in,      // received dlc
  input  wire logic                    eng_fdf_in,      // fd format
  input  wire logic                    eng_brs_in,      // bit rate switch
  input  wire logic                    eng_esi_in,      // error state
  input  wire logic [3:0]              eng_rule_dlc_in, // rule dlc value
  input  wire logic [15:0]             eng_rule_ptr_in, // rule pointer label
  input  wire logic                    eng_rule_ifl0_in,// rule label flag 0
  input  wire logic                    eng_rule_ifl1_in,// rule label flag 1
  input  wire logic [DATA_WORDS*32-1:0] eng_data_in,    // payload, byte 0 low
  input  wire logic                    eng_rx_busy_in,  // reception ongoing
  input  wire logic [1:0]              chan_mode_in,    // channel mode
  output logic                         rx_irq_out,      // store irq pulse
  output logic      [1:0]              pn_status_out    // pn mode status
);

  localparam int unsigned NW = ENT_DATA + DATA_WORDS;
  localparam int unsigned PW = $clog2(FIFO_DEPTH);

  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic       rst_s1_r;
  logic       rst_s2_r;
  logic       rst_n;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  ////////////////////////////////////////////////////////////////////////
  // storage arrays
  logic [31:0] buf_mem_r  [NUM_BUF][NW];
  logic [31:0] fifo_mem_r [2][FIFO_DEPTH][NW];
  logic [31:0] ent        [NW];

  // state
  logic [31:0]     ctrl_r,  ctrl_nxt;
  crxs_pnm_t       pnc_r,   pnc_nxt;
  crxs_pnm_t       pns_r,   pns_nxt;
  logic [15:0]     new_r,   new_nxt;
  logic [3:0]      sel_r,   sel_nxt;
  logic [2:0]      ien_r,   ien_nxt;
  logic [31:0]     fcfg_r   [2];
  logic [31:0]     fcfg_nxt [2];
  logic [PW-1:0]   rp_r [2], rp_nxt [2], wp_r [2], wp_nxt [2];
  logic [5:0]      cnt_r [2], cnt_nxt [2];
  logic [1:0]      lost_r,  lost_nxt;
  logic [31:0]     rdata_r, rdata_nxt;
  logic            irq_r,   irq_nxt;

  // decoded
  logic            pn_act, accept, buf_go;
  logic [1:0]      fifo_go, fifo_wr, fifo_adv;
  logic [7:0]      dep [2];
  logic [6:0]      nbytes;
  logic [3:0]      dlc_st;
  logic [1:0]      rtgt;
  logic [4:0]      nrb;

  always_comb begin
    rtgt   = ctrl_r[CTRL_RTGT_LSB +: 2];
    nrb    = ctrl_r[CTRL_NRB_LSB +: 5];
    pn_act = (pns_r == CRXS_PN_ON) || (pns_r == CRXS_PN_STAY);
    accept = eng_store_in && (!pn_act || eng_pn_match_in);
    buf_go = accept && eng_to_buf_in && ({1'b0, eng_buf_idx_in} < nrb)
             && ({1'b0, eng_buf_idx_in} < 5'(NUM_BUF));
    dlc_st = (ctrl_r[CTRL_DCE] && ctrl_r[CTRL_DRE]) ? eng_rule_dlc_in : eng_dlc_in;
    nbytes = crxs_dlc_bytes(eng_dlc_in);
    ent[ENT_ID]   = eng_id_in;
    ent[ENT_META] = {eng_rule_ptr_in, dlc_st, 10'h000,
                     eng_rule_ifl1_in, eng_rule_ifl0_in};
    ent[ENT_FD]   = {29'h0, eng_fdf_in, eng_fdf_in & eng_brs_in,
                     eng_fdf_in & eng_esi_in};
    for (int w = 0; w < DATA_WORDS; w++) begin
      for (int b = 0; b < 4; b++) begin
        ent[ENT_DATA+w][8*b +: 8] = (7'(4*w+b) < nbytes) ?
                                    eng_data_in[32*w+8*b +: 8] : 8'h00;
      end
    end
    for (int k = 0; k < 2; k++) begin
      dep[k] = crxs_depth(fcfg_r[k][FCFG_DEP_LSB +: 3]);
      if (dep[k] > 8'(FIFO_DEPTH)) begin
        dep[k] = 8'(FIFO_DEPTH);   // depth beyond the built array is clipped
      end
      fifo_go[k]  = accept && eng_to_fifo_in[k] && fcfg_r[k][FCFG_EN];
      fifo_wr[k]  = fifo_go[k] && ({2'b00, cnt_r[k]} != dep[k]);
      fifo_adv[k] = reg_wr_in && (reg_addr_in == OFS_FIFO_PTR + 8'(4*k))
                    && (reg_wdata_in[7:0] == PTR_ADV)
                    && fcfg_r[k][FCFG_EN] && (cnt_r[k] != 6'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state for control and fifo bookkeeping
  always_comb begin
    ctrl_nxt = ctrl_r;
    pnc_nxt  = pnc_r;
    pns_nxt  = pns_r;
    new_nxt  = new_r;
    sel_nxt  = sel_r;
    ien_nxt  = ien_r;
    lost_nxt = lost_r;
    irq_nxt  = 1'b0;
    for (int k = 0; k < 2; k++) begin
      fcfg_nxt[k] = fcfg_r[k];
      rp_nxt[k]   = rp_r[k];
      wp_nxt[k]   = wp_r[k];
      cnt_nxt[k]  = cnt_r[k];
    end

    if (reg_wr_in) begin
      case (reg_addr_in)
        OFS_CTRL:     ctrl_nxt = reg_wdata_in;
        OFS_PN_CTRL: begin
          if (reg_wdata_in[PNC_KEY_LSB +: 8] == PN_KEY) begin
            pnc_nxt = crxs_pnm_t'(reg_wdata_in[1:0]);
          end
        end
        OFS_NEW_DATA: new_nxt = new_r & ~reg_wdata_in[15:0];
        OFS_BUF_SEL:  sel_nxt = reg_wdata_in[3:0];
        OFS_IRQ_EN:   ien_nxt = reg_wdata_in[2:0];
        default: begin
          for (int k = 0; k < 2; k++) begin
            if (reg_addr_in == OFS_FIFO_CFG + 8'(4*k)) begin
              fcfg_nxt[k] = reg_wdata_in;
            end
            if ((reg_addr_in == OFS_FIFO_STS + 8'(4*k)) && reg_wdata_in[FSTS_LOST]) begin
              lost_nxt[k] = 1'b0;
            end
          end
        end
      endcase
    end

    // hardware sets win over software clears
    if (buf_go) begin
      new_nxt[eng_buf_idx_in] = 1'b1;
      irq_nxt = ien_r[0];
    end
    for (int k = 0; k < 2; k++) begin
      if (fifo_go[k] && !fifo_wr[k]) begin
        lost_nxt[k] = 1'b1;
      end
      if (fifo_wr[k]) begin
        irq_nxt   = irq_nxt | ien_r[k+1];
        wp_nxt[k] = (8'(wp_r[k]) + 8'h01 == dep[k]) ? '0 : wp_r[k] + 1'b1;
      end
      if (fifo_adv[k]) begin
        rp_nxt[k] = (8'(rp_r[k]) + 8'h01 == dep[k]) ? '0 : rp_r[k] + 1'b1;
      end
      cnt_nxt[k] = cnt_r[k] + 6'(fifo_wr[k]) - 6'(fifo_adv[k]);
      if (!fcfg_r[k][FCFG_EN]) begin
        rp_nxt[k]  = '0;   // disabling a fifo discards its contents
        wp_nxt[k]  = '0;
        cnt_nxt[k] = 6'h00;
      end
    end

    // a stored matched frame in pn mode sets control to the target unless it says stay
    if ((buf_go || (fifo_wr != 2'b00)) && pn_act && eng_pn_match_in
        && (rtgt != CRXS_PN_STAY)) begin
      pnc_nxt = crxs_pnm_t'(rtgt);
    end
    if (chan_mode_in == CRXS_CH_RESET) begin
      pnc_nxt = CRXS_PN_OFF;
    end
    // status never changes in the middle of a frame
    if (!eng_rx_busy_in) begin
      pns_nxt = pnc_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read
  logic [2:0]  win;
  logic [2:0]  widx;
  logic [31:0] sts [2];

  always_comb begin
    win  = reg_addr_in[7:5];
    widx = reg_addr_in[4:2];
    for (int k = 0; k < 2; k++) begin
      sts[k] = '0;
      sts[k][FSTS_EMPTY] = (cnt_r[k] == 6'h00);
      sts[k][FSTS_FULL]  = ({2'b00, cnt_r[k]} == dep[k]);
      sts[k][FSTS_LOST]  = lost_r[k];
      sts[k][FSTS_CNT_LSB +: 6] = cnt_r[k];
    end
    rdata_nxt = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        OFS_CTRL:             rdata_nxt = ctrl_r;
        OFS_PN_CTRL:          rdata_nxt = {30'h0, pnc_r};
        OFS_PN_STS:           rdata_nxt = {30'h0, pns_r};
        OFS_NEW_DATA:         rdata_nxt = {16'h0, new_r};
        OFS_BUF_SEL:          rdata_nxt = {28'h0, sel_r};
        OFS_IRQ_EN:           rdata_nxt = {29'h0, ien_r};
        OFS_FIFO_CFG:         rdata_nxt = fcfg_r[0];
        OFS_FIFO_CFG + 8'h04: rdata_nxt = fcfg_r[1];
        OFS_FIFO_STS:         rdata_nxt = sts[0];
        OFS_FIFO_STS + 8'h04: rdata_nxt = sts[1];
        default: begin
          // windows show the fifo head and the selected buffer
          if (32'(widx) < NW) begin
            if (win == WIN_FIFO0) begin
              rdata_nxt = fifo_mem_r[0][rp_r[0]][widx];
            end else if (win == WIN_FIFO1) begin
              rdata_nxt = fifo_mem_r[1][rp_r[1]][widx];
            end else if ((win == WIN_BUF) && (32'(sel_r) < NUM_BUF)) begin
              rdata_nxt = buf_mem_r[sel_r][widx];
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= CTRL_RST;
      pnc_r   <= CRXS_PN_OFF;
      pns_r   <= CRXS_PN_OFF;
      new_r   <= 16'h0000;
      sel_r   <= 4'h0;
      ien_r   <= IRQ_EN_RST;
      lost_r  <= 2'h0;
      rdata_r <= 32'h0000_0000;
      irq_r   <= 1'b0;
      for (int k = 0; k < 2; k++) begin
        fcfg_r[k] <= FCFG_RST;
        rp_r[k]   <= '0;
        wp_r[k]   <= '0;
        cnt_r[k]  <= 6'h00;
      end
    end else begin
      ctrl_r  <= ctrl_nxt;
      pnc_r   <= pnc_nxt;
      pns_r   <= pns_nxt;
      new_r   <= new_nxt;
      sel_r   <= sel_nxt;
      ien_r   <= ien_nxt;
      lost_r  <= lost_nxt;
      rdata_r <= rdata_nxt;
      irq_r   <= irq_nxt;
      for (int k = 0; k < 2; k++) begin
        fcfg_r[k] <= fcfg_nxt[k];
        rp_r[k]   <= rp_nxt[k];
        wp_r[k]   <= wp_nxt[k];
        cnt_r[k]  <= cnt_nxt[k];
      end
    end
  end

  // memories carry no reset; the windows read them unguarded, so unwritten entries read as unknown
  always_ff @(posedge clk_in) begin
    if (buf_go) begin
      buf_mem_r[eng_buf_idx_in] <= ent;
    end
    for (int k = 0; k < 2; k++) begin
      if (fifo_wr[k]) begin
        fifo_mem_r[k][wp_r[k]] <= ent;
      end
    end
  end

  assign reg_rdata_out = rdata_r;
  assign rx_irq_out    = irq_r;
  assign pn_status_out = pns_r;

endmodule

`default_nettype wire

// ==== common/crxs_pkg.sv ====
// crxs_pkg: register map, field layout, reset values and mode codes
// for the receive storage block; shared by design and bench
package crxs_pkg;

  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PN_CTRL  = 8'h04;
  localparam logic [7:0] OFS_PN_STS   = 8'h08;
  localparam logic [7:0] OFS_NEW_DATA = 8'h0c;
  localparam logic [7:0] OFS_BUF_SEL  = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
  localparam logic [7:0] OFS_FIFO_CFG = 8'h20;  // + 4*k
  localparam logic [7:0] OFS_FIFO_STS = 8'h28;  // + 4*k
  localparam logic [7:0] OFS_FIFO_PTR = 8'h30;  // + 4*k
  localparam logic [2:0] WIN_FIFO0    = 3'h2;   // 0x40..0x5f
  localparam logic [2:0] WIN_FIFO1    = 3'h3;   // 0x60..0x7f
  localparam logic [2:0] WIN_BUF      = 3'h4;   // 0x80..0x9f

  // word order inside a stored entry / read window
  localparam int unsigned ENT_ID   = 0;
  localparam int unsigned ENT_META = 1;
  localparam int unsigned ENT_FD   = 2;
  localparam int unsigned ENT_DATA = 3;

  // field positions
  localparam int unsigned CTRL_DCE      = 0;
  localparam int unsigned CTRL_DRE      = 1;
  localparam int unsigned CTRL_RTGT_LSB = 2;
  localparam int unsigned CTRL_NRB_LSB  = 8;
  localparam int unsigned CTRL_PLS_LSB  = 16;
  localparam int unsigned PNC_KEY_LSB   = 8;
  localparam int unsigned FCFG_EN       = 0;
  localparam int unsigned FCFG_PLS_LSB  = 4;
  localparam int unsigned FCFG_DEP_LSB  = 8;
  localparam int unsigned FSTS_EMPTY    = 0;
  localparam int unsigned FSTS_FULL     = 1;
  localparam int unsigned FSTS_LOST     = 2;
  localparam int unsigned FSTS_CNT_LSB  = 8;
  localparam int unsigned META_DLC_LSB  = 12;
  localparam int unsigned META_PTR_LSB  = 16;

  // reset values and keys
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] FCFG_RST   = 32'h0000_0000;
  localparam logic [2:0]  IRQ_EN_RST = 3'h0;
  localparam logic [7:0]  PN_KEY     = 8'hc4;
  localparam logic [7:0]  PTR_ADV    = 8'hff;

  typedef enum logic [1:0] {
    CRXS_PN_OFF  = 2'b00,
    CRXS_PN_ON   = 2'b01,
    CRXS_PN_ALT  = 2'b10,
    CRXS_PN_STAY = 2'b11
  } crxs_pnm_t;

  typedef enum logic [1:0] {
    CRXS_CH_OPER  = 2'b00,
    CRXS_CH_RESET = 2'b01,
    CRXS_CH_HALT  = 2'b10,
    CRXS_CH_SLEEP = 2'b11
  } crxs_chm_t;

  // depth code to message count
  function automatic logic [7:0] crxs_depth(input logic [2:0] code);
    case (code)
      3'h0:    crxs_depth = 8'h00;
      3'h1:    crxs_depth = 8'h04;
      3'h2:    crxs_depth = 8'h08;
      3'h3:    crxs_depth = 8'h10;
      3'h4:    crxs_depth = 8'h20;
      3'h5:    crxs_depth = 8'h30;
      3'h6:    crxs_depth = 8'h40;
      default: crxs_depth = 8'h80;
    endcase
  endfunction

  // dlc to payload bytes
  function automatic logic [6:0] crxs_dlc_bytes(input logic [3:0] dlc);
    case (dlc)
      4'h9:    crxs_dlc_bytes = 7'h0c;
      4'ha:    crxs_dlc_bytes = 7'h10;
      4'hb:    crxs_dlc_bytes = 7'h14;
      4'hc:    crxs_dlc_bytes = 7'h18;
      4'hd:    crxs_dlc_bytes = 7'h20;
      4'he:    crxs_dlc_bytes = 7'h30;
      4'hf:    crxs_dlc_bytes = 7'h40;
      default: crxs_dlc_bytes = {3'h0, dlc};
    endcase
  endfunction

endpackage

// ==== verif/crxs_rx_storage_props.sv ====
// crxs_rx_storage_props: port-level checks for the receive storage block
// sees only the top ports; bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
module crxs_rx_storage_props
  import crxs_pkg::*;
(
  input wire logic              clk_in,          // clock
  input wire logic              rst_n_in,        // reset
  input wire logic [crxs_pkg::ADDR_W-1:0] reg_addr_in, // address
  input wire logic [31:0]       reg_wdata_in,    // write data
  input wire logic              reg_wr_in,       // write strobe
  input wire logic              reg_rd_in,       // read strobe
  input wire logic [31:0]       reg_rdata_out,   // read data
  input wire logic              eng_store_in,    // store pulse
  input wire logic              eng_pn_match_in, // pn match
  input wire logic              eng_rx_busy_in,  // receiving
  input wire logic [1:0]        chan_mode_in,    // channel mode
  input wire logic              rx_irq_out,      // irq pulse
  input wire logic [1:0]        pn_status_out    // pn status
);
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic       keyed_wr;
  logic [1:0] wr_mode;
  // only an idle write with no competing cause has a fixed outcome
  assign keyed_wr = reg_wr_in && reg_addr_in == OFS_PN_CTRL && reg_wdata_in[15:8] == PN_KEY
                    && !eng_store_in && chan_mode_in != CRXS_CH_RESET && !eng_rx_busy_in;
  assign wr_mode  = reg_wdata_in[1:0];
  property p_keyed;
    keyed_wr ##1 !eng_rx_busy_in |=> pn_status_out == $past(wr_mode, 2);
  endproperty
  a_keyed: assert property (p_keyed) else $error("keyed mode write not reflected");
  property p_busy_hold;
    $changed(pn_status_out) |-> !$past(eng_rx_busy_in);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("status moved in reception");
  property p_chan_reset;
    (chan_mode_in == CRXS_CH_RESET && !eng_rx_busy_in) [*2] |=> pn_status_out == CRXS_PN_OFF;
  endproperty
  a_chan_reset: assert property (p_chan_reset) else $error("reset kept pn mode");
  property p_pn_drop;
    eng_store_in && !eng_pn_match_in && pn_status_out[0] |=> !rx_irq_out;
  endproperty
  a_pn_drop: assert property (p_pn_drop) else $error("unmatched frame raised irq");
  property p_irq_cause;
    rx_irq_out |-> $past(eng_store_in);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without a store");
  property p_irq_pulse;
    rx_irq_out && !eng_store_in |=> !rx_irq_out;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a pulse");
  property p_rdata_idle;
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  property p_unmapped;
    reg_rd_in && reg_addr_in == 8'hfc |=> reg_rdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_irq: cover property (rx_irq_out);
  c_keyed: cover property (keyed_wr);
  c_recover: cover property (pn_status_out == CRXS_PN_ON ##[1:60] pn_status_out == CRXS_PN_OFF);
endmodule
`default_nettype wire

// ==== verif/crxs_eng_model.sv ====
// crxs_eng_model: protocol engine stand-in handing filtered frames over
// frames are started by the bench through the send task
`timescale 1ns/100ps
`default_nettype none
module crxs_eng_model
  import crxs_pkg::*;
#(
  parameter int unsigned DATA_WORDS = 2
) (
  input  wire logic                clk_in,            // clock
  output logic                     eng_store_out,     // store pulse
  output logic                     eng_to_buf_out,    // to buffer
  output logic [3:0]               eng_buf_idx_out,   // buffer index
  output logic [1:0]               eng_to_fifo_out,   // fifo select
  output logic                     eng_pn_match_out,  // pn match
  output logic [31:0]              eng_id_out,        // id word
  output logic [3:0]               eng_dlc_out,       // dlc
  output logic                     eng_fdf_out,       // fd format
  output logic                     eng_brs_out,       // rate switch
  output logic                     eng_esi_out,       // error state
  output logic [3:0]               eng_rule_dlc_out,  // rule dlc
  output logic [15:0]              eng_rule_ptr_out,  // rule label
  output logic                     eng_rule_ifl0_out, // label flag 0
  output logic                     eng_rule_ifl1_out, // label flag 1
  output logic [DATA_WORDS*32-1:0] eng_data_out,      // payload
  output logic                     eng_rx_busy_out    // receiving
);
  ////////////////////////////////////////////////////////////
  initial begin
    {eng_store_out, eng_to_buf_out, eng_buf_idx_out, eng_to_fifo_out, eng_pn_match_out} = '0;
    {eng_id_out, eng_dlc_out, eng_fdf_out, eng_brs_out, eng_esi_out, eng_data_out} = '0;
    {eng_rule_dlc_out, eng_rule_ptr_out, eng_rule_ifl0_out, eng_rule_ifl1_out} = '0;
    eng_rx_busy_out = 1'b0;
  end
  // unqualified id, payload, dlc, rule dlc and pointer show the inverse, so a late sample never matches
  always @(posedge clk_in) begin
    if (eng_store_out) begin
      eng_store_out <= 1'b0;
      {eng_id_out, eng_data_out} <= ~{eng_id_out, eng_data_out};
      {eng_dlc_out, eng_rule_dlc_out, eng_rule_ptr_out} <=
        ~{eng_dlc_out, eng_rule_dlc_out, eng_rule_ptr_out};
    end
  end
  task automatic send(input logic to_b, input logic [3:0] idx, input logic [1:0] fifo,
                      input logic pnm, input int unsigned slow);
    @(posedge clk_in);
    eng_rx_busy_out <= 1'b1;
    repeat (slow + 1) @(posedge clk_in);
    eng_rx_busy_out  <= 1'b0;
    eng_store_out    <= 1'b1;
    eng_to_buf_out   <= to_b;
    eng_buf_idx_out  <= idx;
    eng_to_fifo_out  <= fifo[0] ? 2'b01 : fifo;
    eng_pn_match_out <= pnm;
    eng_id_out       <= $urandom;
    eng_dlc_out      <= 4'($urandom);
    {eng_fdf_out, eng_brs_out, eng_esi_out} <= 3'($urandom);
    eng_rule_dlc_out <= 4'($urandom);
    eng_rule_ptr_out <= 16'($urandom);
    {eng_rule_ifl1_out, eng_rule_ifl0_out} <= 2'($urandom);
    for (int w = 0; w < DATA_WORDS; w++) eng_data_out[w*32 +: 32] <= $urandom;
  endtask
endmodule
`default_nettype wire

// ==== verif/crxs_rx_storage_tb.sv ====
// crxs_rx_storage_tb: self-checking bench for the receive storage block
// assumes crxs_eng_model in place of the protocol engine
`timescale 1ns/100ps
`default_nettype none
module crxs_rx_storage_tb;
  import crxs_pkg::*;
  logic              clk_in, rst_n_in, reg_wr_in, reg_rd_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [31:0]       reg_wdata_in, x_id, x_meta, x_fd, q[$];
  logic [1:0]        chan_mode_in, dd;
  logic [63:0]       x_data;
  logic [3:0]        ix;
  int                num_errors, tests_run, cyc;
  wire logic [31:0]  reg_rdata_out, eng_id_in;
  wire logic [63:0]  eng_data_in;
  wire logic [15:0]  eng_rule_ptr_in;
  wire logic [3:0]   eng_buf_idx_in, eng_dlc_in, eng_rule_dlc_in;
  wire logic [1:0]   eng_to_fifo_in, pn_status_out;
  wire logic         eng_store_in, eng_to_buf_in, eng_pn_match_in, eng_fdf_in, eng_brs_in;
  wire logic         eng_esi_in, eng_rule_ifl0_in, eng_rule_ifl1_in, eng_rx_busy_in, rx_irq_out;
  crxs_rx_storage #(.NUM_BUF(16), .FIFO_DEPTH(16), .DATA_WORDS(2)) crxs_rx_storage_i (
    .clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .eng_store_in, .eng_to_buf_in, .eng_buf_idx_in, .eng_to_fifo_in, .eng_pn_match_in,
    .eng_id_in, .eng_dlc_in, .eng_fdf_in, .eng_brs_in, .eng_esi_in, .eng_rule_dlc_in,
    .eng_rule_ptr_in, .eng_rule_ifl0_in, .eng_rule_ifl1_in, .eng_data_in, .eng_rx_busy_in,
    .chan_mode_in, .rx_irq_out, .pn_status_out);
  crxs_eng_model #(.DATA_WORDS(2)) crxs_eng_model_i (
    .clk_in, .eng_store_out(eng_store_in), .eng_to_buf_out(eng_to_buf_in),
    .eng_buf_idx_out(eng_buf_idx_in), .eng_to_fifo_out(eng_to_fifo_in),
    .eng_pn_match_out(eng_pn_match_in), .eng_id_out(eng_id_in), .eng_dlc_out(eng_dlc_in),
    .eng_fdf_out(eng_fdf_in), .eng_brs_out(eng_brs_in), .eng_esi_out(eng_esi_in),
    .eng_rule_dlc_out(eng_rule_dlc_in), .eng_rule_ptr_out(eng_rule_ptr_in),
    .eng_rule_ifl0_out(eng_rule_ifl0_in), .eng_rule_ifl1_out(eng_rule_ifl1_in),
    .eng_data_out(eng_data_in), .eng_rx_busy_out(eng_rx_busy_in));
  ////////////////////////////////////////////////////////////
  function automatic logic [63:0] fill(input logic [63:0] d, input logic [3:0] dlc);
    fill = d;
    for (int b = 0; b < 8; b++) if (b >= dlc) fill[b*8 +: 8] = 8'h00;
  endfunction
  function automatic logic [31:0] sts(input int c, input logic lost);
    sts = {18'h0, 6'(c), 5'h0, lost, c == 4, c == 0}; // full at a depth of four
  endfunction
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out & m, e);
  endtask
  task automatic frame(input logic to_b, input logic [3:0] i, input logic [1:0] f,
                       input logic p, input int unsigned s);
    crxs_eng_model_i.send(to_b, i, f, p, s);
    #1;
    x_id   = eng_id_in;
    x_meta = {eng_rule_ptr_in, &dd ? eng_rule_dlc_in : eng_dlc_in, 10'h0,
              eng_rule_ifl1_in, eng_rule_ifl0_in};
    x_fd   = {29'h0, eng_fdf_in, eng_fdf_in & eng_brs_in, eng_fdf_in & eng_esi_in};
    x_data = fill(eng_data_in, eng_dlc_in);
    @(posedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    {rst_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, dd} = '0;
    chan_mode_in = CRXS_CH_OPER;
    void'($urandom(32'h1fcc));
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd_chk(OFS_CTRL, '1, CTRL_RST);
    rd_chk(OFS_FIFO_CFG, '1, FCFG_RST);
    rd_chk(OFS_IRQ_EN, 32'h7, 32'(IRQ_EN_RST));
    rd_chk(OFS_PN_STS, 32'h3, 32'h0);
    rd_chk(8'hfc, '1, 32'h0);
    wr(OFS_IRQ_EN, 32'h7);
    // the first two frames share buffer 15, so the second must overwrite
    for (int i = 0; i < 6; i++) begin
      ix = (i < 2) ? 4'hf : 4'($urandom);
      dd = (i < 2) ? {1'b1, 1'(i)} : 2'($urandom);
      wr(OFS_CTRL, {16'h0, 8'h10, 6'h0, dd});
      wr(OFS_BUF_SEL, {28'h0, ix});
      frame(1'b1, ix, 2'b00, 1'b0, i);
      #1 chk(32'(rx_irq_out), 32'h1);
      rd_chk(OFS_NEW_DATA, 32'h1 << ix, 32'h1 << ix);
      rd_chk(8'h80, '1, x_id);
      rd_chk(8'h84, '1, x_meta);
      rd_chk(8'h88, '1, x_fd);
      rd_chk(8'h8c, '1, x_data[31:0]);
      rd_chk(8'h90, '1, x_data[63:32]);
      wr(OFS_NEW_DATA, 32'h1 << ix);
    end
    wr(OFS_FIFO_CFG, 32'h0000_0101);
    for (int i = 0; i < 5; i++) begin
      frame(1'b0, 4'h0, 2'b11, 1'b0, 0);
      if (i < 4) q.push_back(x_id);
      rd_chk(OFS_FIFO_STS, '1, sts(i < 4 ? i + 1 : 4, i == 4));
    end
    frame(1'b0, 4'h0, 2'b10, 1'b0, 0);
    rd_chk(OFS_FIFO_STS + 8'h04, 32'h3f04, 32'h0);
    wr(OFS_FIFO_PTR, 32'h0000_00fe);
    rd_chk(OFS_FIFO_STS, 32'h3f00, 32'h0400);
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'h40, '1, q.pop_front());
      wr(OFS_FIFO_PTR, 32'h0000_00ff);
    end
    rd_chk(OFS_FIFO_STS, 32'h3f03, 32'h0001);
    wr(OFS_FIFO_CFG, 32'h0000_0201);
    wr(OFS_PN_CTRL, 32'h0000_0001);
    rd_chk(OFS_PN_STS, 32'h3, 32'h0);
    wr(OFS_PN_CTRL, {16'h0, PN_KEY, 8'h02});
    rd_chk(OFS_PN_STS, 32'h3, 32'h2);
    wr(OFS_PN_CTRL, {16'h0, PN_KEY, 8'h00});
    for (int t = 0; t < 4; t++) begin
      @(posedge clk_in) chan_mode_in <= t[0] ? CRXS_CH_HALT : CRXS_CH_OPER;
      wr(OFS_CTRL, {28'h0, 2'(t), 2'b00});
      // the keyed write lands while a frame is still being received
      fork
        frame(1'b0, 4'h0, 2'b00, 1'b0, 12);
        begin
          wr(OFS_PN_CTRL, {16'h0, PN_KEY, 8'h01});
          rd_chk(OFS_PN_STS, 32'h3, 32'h0);
        end
      join
      rd_chk(OFS_PN_STS, 32'h3, 32'h1);
      frame(1'b0, 4'h0, 2'b01, 1'b0, 0);
      rd_chk(OFS_FIFO_STS, 32'h3f00, {18'h0, 6'(t), 8'h0});
      frame(1'b0, 4'h0, 2'b01, 1'b1, 0);
      #1 chk(32'(rx_irq_out), 32'h1);
      rd_chk(OFS_FIFO_STS, 32'h3f00, {18'h0, 6'(t + 1), 8'h0});
      rd_chk(OFS_PN_STS, 32'h3, (t == 3) ? 32'h1 : 32'(t));
      @(posedge clk_in) chan_mode_in <= CRXS_CH_RESET;
      repeat (3) @(posedge clk_in);
      rd_chk(OFS_PN_STS, 32'h3, 32'h0);
    end
    give_verdict();
  end
endmodule
bind crxs_rx_storage crxs_rx_storage_props crxs_rx_storage_props_i (.*);
`default_nettype wire
